// file: rtl/irc_pkg.sv
// constants for the infrared carrier modulation timer
package irc_pkg;
	// ------------------------------------------------------------
	// register byte offsets
	// ------------------------------------------------------------
	localparam logic [7:0] OFF_CONTROL = 8'h00;
	localparam logic [7:0] OFF_CARRIER = 8'h04;
	localparam logic [7:0] OFF_MODTIME = 8'h08;
	localparam logic [7:0] OFF_COUNT = 8'h0c;
	localparam logic [7:0] OFF_STATUS = 8'h10;
	// ------------------------------------------------------------
	// control register fields
	// ------------------------------------------------------------
	localparam int B_ENABLE = 0;
	localparam int B_TX_MODE = 1;
	localparam int B_CLK_SEL = 2;
	localparam int B_RELOAD = 3;
	localparam int B_EDGE_LO = 4;
	localparam int B_DIV_LO = 6;
	localparam int B_POLARITY = 8;
	localparam int B_LEVEL = 9;
	localparam int B_IRQ_EN = 10;
	localparam int B_MAN_LEVEL = 11;
	localparam int B_MAN_OE = 12;
	localparam logic [15:0] CONTROL_MASK = 16'h1fff;
	localparam logic [15:0] CONTROL_RESET = 16'h0000;
	// ------------------------------------------------------------
	// status register fields, write one to clear
	// ------------------------------------------------------------
	localparam int B_EVENT = 0;
	localparam int B_OVERFLOW = 1;
	// ------------------------------------------------------------
	// receive edge select codes
	// ------------------------------------------------------------
	localparam logic [1:0] EDGE_FALL = 2'h0;
	localparam logic [1:0] EDGE_RISE = 2'h1;
	// ------------------------------------------------------------
	// reset values and bus answers
	// ------------------------------------------------------------
	localparam logic [15:0] CARRIER_RESET = 16'h0000;
	localparam logic [15:0] MODTIME_RESET = 16'h0000;
	localparam logic [15:0] COUNT_RESET = 16'h0000;
	localparam logic [15:0] COUNT_ZERO = 16'h0000;
	localparam logic [15:0] COUNT_MAX = 16'hffff;
	localparam logic [15:0] COUNT_ONE = 16'h0001;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : irc_pkg

// file: rtl/irc_carrier_gen.sv
// carrier waveform generator, high and low phase counts
`timescale 1ns/100ps
`default_nettype none
module irc_carrier_gen #(
	parameter int BW = 8
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic restart,
	input wire logic tick,
	input wire logic [BW-1:0] high_count,
	input wire logic [BW-1:0] low_count,
	output logic carrier_level,
	output logic cycle_done
);
	logic [BW-1:0] phase_cnt_reg;
	logic high_reg;
	logic [BW-1:0] limit;
	logic done_reg;

	assign limit = high_reg ? high_count : low_count;
	assign carrier_level = high_reg;
	assign cycle_done = done_reg;

	// ------------------------------------------------------------
	// phase timing, each phase lasts count plus one ticks
	// ------------------------------------------------------------
	always_ff @(posedge aclk) begin
		done_reg <= 1'b0;
		if (!aresetn || restart) begin
			phase_cnt_reg <= '0;
			high_reg <= 1'b1;
		end else if (tick) begin
			if (phase_cnt_reg == limit) begin
				phase_cnt_reg <= '0;
				high_reg <= ~high_reg;
				done_reg <= ~high_reg;
			end else begin
				phase_cnt_reg <= phase_cnt_reg + BW'(1);
			end
		end
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	AST_HIGH_PHASE_END: assert property (
		!restart && tick && high_reg && phase_cnt_reg == high_count
		##1 !restart |-> !high_reg)
		else $error("high phase did not end at count");
	AST_PHASE_HOLD: assert property (
		!restart && !tick |=> restart || $stable(high_reg))
		else $error("carrier phase moved without tick");
endmodule : irc_carrier_gen
`default_nettype wire

// file: rtl/irc_timer.sv
// infrared carrier timer top with axi4-lite register slave
//
// Added by the designer: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
module irc_timer #(
	parameter int AW = 8,
	parameter int CW = 16
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [AW-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [AW-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic infrared_receive_pin,
	output logic infrared_transmit_pin,
	output logic infrared_transmit_pin_oe,
	output logic irq
);
	logic [15:0] power_port_control_reg;
	logic [15:0] carrier_timing_reg;
	logic [CW-1:0] modulation_time_reg;
	logic [CW-1:0] timer_count_value_reg;
	logic [1:0] status_reg;
	logic [1:0] status_next;
	logic [15:0] carrier_latch_reg;
	logic level_latch_reg;
	logic pol_latch_reg;
	logic tx_run_prev_reg;
	logic rx_meta_reg;
	logic rx_sync_reg;
	logic rx_prev_reg;
	logic [2:0] presc_reg;
	logic [AW-1:0] waddr_reg;
	logic [31:0] wdata_reg;
	logic [3:0] wstrb_reg;
	logic aw_held_reg;
	logic w_held_reg;
	logic tx_out_reg;
	logic tx_oe_reg;
	logic irq_reg;
	logic [31:0] rdata_reg;
	logic [1:0] rresp_reg;
	logic rvalid_reg;
	logic arready_reg;
	logic [1:0] bresp_reg;
	logic bvalid_reg;
	logic infrared_timer_enable;
	logic tx_mode;
	logic count_clock_select;
	logic capture_reload_enable;
	logic [1:0] edge_select;
	logic [1:0] input_clock_divider;
	logic transmit_polarity;
	logic modulator_level_bit;
	logic infrared_interrupt_enable;
	logic manual_tx_level;
	logic manual_tx_drive_enable;
	logic tx_run;
	logic rx_run;
	logic tx_start;
	logic infrared_input_clock;
	logic carrier_level;
	logic carrier_cycle;
	logic count_tick;
	logic rx_rise;
	logic rx_fall;
	logic rx_edge;
	logic wr_fire;
	logic wr_control;
	logic wr_carrier;
	logic wr_modtime;
	logic wr_count;
	logic wr_status;
	logic wr_known;
	logic [15:0] wr_half;
	logic [15:0] carrier_use;
	logic count_zero;
	logic tx_reload;

	// ------------------------------------------------------------
	// decode helpers
	// ------------------------------------------------------------
	function automatic logic hit(input logic [AW-1:0] a,
		input logic [7:0] off);
		hit = a[AW-1:2] == off[AW-1:2];
	endfunction : hit

	function automatic logic [15:0] merge(input logic [15:0] old,
		input logic [31:0] d, input logic [3:0] s);
		merge = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
	endfunction : merge

	function automatic logic [2:0] div_mask(input logic [1:0] d);
		case (d)
			2'h0: div_mask = 3'h0;
			2'h1: div_mask = 3'h1;
			2'h2: div_mask = 3'h3;
			default: div_mask = 3'h7;
		endcase
	endfunction : div_mask

	// ------------------------------------------------------------
	// control fields
	// ------------------------------------------------------------
	assign infrared_timer_enable = power_port_control_reg[irc_pkg::B_ENABLE];
	assign tx_mode = power_port_control_reg[irc_pkg::B_TX_MODE];
	assign count_clock_select = power_port_control_reg[irc_pkg::B_CLK_SEL];
	assign capture_reload_enable = power_port_control_reg[irc_pkg::B_RELOAD];
	assign edge_select =
		power_port_control_reg[irc_pkg::B_EDGE_LO +: 2];
	assign input_clock_divider =
		power_port_control_reg[irc_pkg::B_DIV_LO +: 2];
	assign transmit_polarity = power_port_control_reg[irc_pkg::B_POLARITY];
	assign modulator_level_bit = power_port_control_reg[irc_pkg::B_LEVEL];
	assign infrared_interrupt_enable =
		power_port_control_reg[irc_pkg::B_IRQ_EN];
	assign manual_tx_level = power_port_control_reg[irc_pkg::B_MAN_LEVEL];
	assign manual_tx_drive_enable = power_port_control_reg[irc_pkg::B_MAN_OE];

	assign tx_run = infrared_timer_enable && tx_mode;
	assign rx_run = infrared_timer_enable && !tx_mode;
	assign tx_start = tx_run && !tx_run_prev_reg;

	// ------------------------------------------------------------
	// write decode
	// ------------------------------------------------------------
	assign wr_fire = aw_held_reg && w_held_reg && !bvalid_reg;
	assign wr_control = wr_fire && hit(waddr_reg, irc_pkg::OFF_CONTROL);
	assign wr_carrier = wr_fire && hit(waddr_reg, irc_pkg::OFF_CARRIER);
	assign wr_modtime = wr_fire && hit(waddr_reg, irc_pkg::OFF_MODTIME);
	assign wr_count = wr_fire && hit(waddr_reg, irc_pkg::OFF_COUNT);
	assign wr_status = wr_fire && hit(waddr_reg, irc_pkg::OFF_STATUS);
	assign wr_known = wr_control || wr_carrier || wr_modtime ||
		wr_count || wr_status;

	// ------------------------------------------------------------
	// axi4-lite write channels
	// ------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_reg <= 1'b0;
			w_held_reg <= 1'b0;
			waddr_reg <= '0;
			wdata_reg <= 32'h0;
			wstrb_reg <= 4'h0;
			bvalid_reg <= 1'b0;
			bresp_reg <= irc_pkg::RESP_OKAY;
		end else begin
			if (s_axi_awvalid && !aw_held_reg) begin
				aw_held_reg <= 1'b1;
				waddr_reg <= s_axi_awaddr;
			end
			if (s_axi_wvalid && !w_held_reg) begin
				w_held_reg <= 1'b1;
				wdata_reg <= s_axi_wdata;
				wstrb_reg <= s_axi_wstrb;
			end
			if (wr_fire) begin
				bvalid_reg <= 1'b1;
				bresp_reg <= wr_known ? irc_pkg::RESP_OKAY :
					irc_pkg::RESP_SLVERR;
			end else if (bvalid_reg && s_axi_bready) begin
				bvalid_reg <= 1'b0;
				aw_held_reg <= 1'b0;
				w_held_reg <= 1'b0;
			end
		end
	end
	assign s_axi_awready = !aw_held_reg;
	assign s_axi_wready = !w_held_reg;
	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp = bresp_reg;
	assign wr_half = wdata_reg[15:0];

	// ------------------------------------------------------------
	// axi4-lite read channel
	// ------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_reg <= 1'b1;
			rvalid_reg <= 1'b0;
			rdata_reg <= 32'h0;
			rresp_reg <= irc_pkg::RESP_OKAY;
		end else if (s_axi_arvalid && arready_reg) begin
			arready_reg <= 1'b0;
			rvalid_reg <= 1'b1;
			rresp_reg <= irc_pkg::RESP_OKAY;
			if (hit(s_axi_araddr, irc_pkg::OFF_CONTROL)) begin
				rdata_reg <= {16'h0, power_port_control_reg};
			end else if (hit(s_axi_araddr, irc_pkg::OFF_CARRIER)) begin
				rdata_reg <= {16'h0, carrier_timing_reg};
			end else if (hit(s_axi_araddr, irc_pkg::OFF_MODTIME)) begin
				rdata_reg <= {16'h0, modulation_time_reg};
			end else if (hit(s_axi_araddr, irc_pkg::OFF_COUNT)) begin
				rdata_reg <= {16'h0, timer_count_value_reg};
			end else if (hit(s_axi_araddr, irc_pkg::OFF_STATUS)) begin
				rdata_reg <= {30'h0, status_reg};
			end else begin
				rdata_reg <= 32'h0;
				rresp_reg <= irc_pkg::RESP_SLVERR;
			end
		end else if (rvalid_reg && s_axi_rready) begin
			rvalid_reg <= 1'b0;
			arready_reg <= 1'b1;
		end
	end
	assign s_axi_arready = arready_reg;
	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rdata = rdata_reg;
	assign s_axi_rresp = rresp_reg;

	// ------------------------------------------------------------
	// receive pin synchroniser and edge qualifier
	// ------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rx_meta_reg <= 1'b0;
			rx_sync_reg <= 1'b0;
			rx_prev_reg <= 1'b0;
		end else begin
			rx_meta_reg <= infrared_receive_pin;
			rx_sync_reg <= rx_meta_reg;
			rx_prev_reg <= rx_sync_reg;
		end
	end
	assign rx_rise = rx_sync_reg && !rx_prev_reg;
	assign rx_fall = !rx_sync_reg && rx_prev_reg;
	assign rx_edge = rx_run && (edge_select == irc_pkg::EDGE_FALL ? rx_fall :
		edge_select == irc_pkg::EDGE_RISE ? rx_rise : rx_rise || rx_fall);

	// ------------------------------------------------------------
	// input clock divider and carrier
	// ------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn || !infrared_timer_enable) begin
			presc_reg <= 3'h0;
		end else begin
			presc_reg <= presc_reg + 3'h1;
		end
	end
	assign infrared_input_clock = infrared_timer_enable &&
		(presc_reg & div_mask(input_clock_divider)) ==
		div_mask(input_clock_divider);

	assign carrier_use = tx_run ? carrier_latch_reg : carrier_timing_reg;

	irc_carrier_gen #(.BW(8)) u_carrier (
		.aclk(aclk),
		.aresetn(aresetn),
		.restart(!infrared_timer_enable || tx_start),
		.tick(infrared_input_clock),
		.high_count(carrier_use[15:8]),
		.low_count(carrier_use[7:0]),
		.carrier_level(carrier_level),
		.cycle_done(carrier_cycle)
	);

	assign count_tick = count_clock_select ? infrared_input_clock :
		carrier_cycle;
	assign count_zero = timer_count_value_reg == irc_pkg::COUNT_ZERO;
	assign tx_reload = tx_run && !tx_start && count_tick && count_zero;

	// ------------------------------------------------------------
	// count value
	// ------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			timer_count_value_reg <= irc_pkg::COUNT_RESET;
		end else if (wr_count) begin
			timer_count_value_reg <= merge(timer_count_value_reg,
				wdata_reg, wstrb_reg);
		end else if (tx_start || tx_reload) begin
			timer_count_value_reg <= modulation_time_reg;
		end else if (rx_edge && capture_reload_enable) begin
			timer_count_value_reg <= irc_pkg::COUNT_ZERO;
		end else if (tx_run && count_tick) begin
			timer_count_value_reg <= timer_count_value_reg -
				irc_pkg::COUNT_ONE;
		end else if (rx_run && count_tick) begin
			timer_count_value_reg <= timer_count_value_reg +
				irc_pkg::COUNT_ONE;
		end
	end

	// ------------------------------------------------------------
	// modulation time, capture and transmit sample latches
	// ------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			modulation_time_reg <= irc_pkg::MODTIME_RESET;
			carrier_timing_reg <= irc_pkg::CARRIER_RESET;
			power_port_control_reg <= irc_pkg::CONTROL_RESET;
			carrier_latch_reg <= irc_pkg::CARRIER_RESET;
			level_latch_reg <= 1'b0;
			pol_latch_reg <= 1'b0;
			tx_run_prev_reg <= 1'b0;
		end else begin
			tx_run_prev_reg <= tx_run;
			if (rx_edge) begin
				modulation_time_reg <= timer_count_value_reg;
				power_port_control_reg[irc_pkg::B_LEVEL] <= rx_sync_reg;
			end
			if (wr_modtime) begin
				modulation_time_reg <= merge(modulation_time_reg,
					wdata_reg, wstrb_reg);
			end
			if (wr_carrier) begin
				carrier_timing_reg <= merge(carrier_timing_reg,
					wdata_reg, wstrb_reg);
			end
			if (wr_control) begin
				power_port_control_reg <= merge(power_port_control_reg,
					wdata_reg, wstrb_reg) & irc_pkg::CONTROL_MASK;
			end
			if (tx_start || tx_reload) begin
				carrier_latch_reg <= carrier_timing_reg;
				level_latch_reg <= modulator_level_bit;
				pol_latch_reg <= transmit_polarity;
			end
		end
	end

	// ------------------------------------------------------------
	// status flags, hardware set wins over clear
	// ------------------------------------------------------------
	always_comb begin
		status_next = status_reg;
		if (wr_status && wstrb_reg[0]) begin
			status_next = status_reg & ~wdata_reg[1:0];
		end
		if (tx_reload || rx_edge) begin
			status_next[irc_pkg::B_EVENT] = 1'b1;
		end
		if (rx_run && count_tick && !(rx_edge && capture_reload_enable) &&
			!wr_count && timer_count_value_reg == irc_pkg::COUNT_MAX) begin
			status_next[irc_pkg::B_OVERFLOW] = 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			status_reg <= 2'h0;
			irq_reg <= 1'b0;
		end else begin
			status_reg <= status_next;
			irq_reg <= infrared_interrupt_enable && (|status_next);
		end
	end
	assign irq = irq_reg;

	// ------------------------------------------------------------
	// transmit pin
	// ------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tx_out_reg <= 1'b0;
			tx_oe_reg <= 1'b0;
		end else if (!infrared_timer_enable) begin
			tx_out_reg <= manual_tx_level;
			tx_oe_reg <= manual_tx_drive_enable;
		end else begin
			tx_oe_reg <= 1'b1;
			if (tx_run && level_latch_reg) begin
				tx_out_reg <= carrier_level ^ pol_latch_reg;
			end else begin
				tx_out_reg <= tx_run ? pol_latch_reg : transmit_polarity;
			end
		end
	end
	assign infrared_transmit_pin = tx_out_reg;
	assign infrared_transmit_pin_oe = tx_oe_reg;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	AST_TX_DOWN: assert property (
		tx_run && !tx_start && count_tick && !count_zero && !wr_count |=>
		timer_count_value_reg == $past(timer_count_value_reg) - 16'h0001)
		else $error("transmit count did not decrement");
	AST_TX_RELOAD: assert property (
		tx_reload && !wr_count |=>
		timer_count_value_reg == $past(modulation_time_reg) &&
		status_reg[irc_pkg::B_EVENT])
		else $error("reload at zero missing");
	AST_RX_UP: assert property (
		rx_run && count_tick && !rx_edge && !wr_count |=>
		timer_count_value_reg == $past(timer_count_value_reg) + 16'h0001)
		else $error("receive count did not increment");
	AST_RX_RELOAD: assert property (
		rx_edge && capture_reload_enable && !wr_count |=>
		timer_count_value_reg == 16'h0000)
		else $error("capture reload to zero missing");
	AST_CAPTURE: assert property (
		rx_edge && !wr_modtime && !wr_control |=>
		modulation_time_reg == $past(timer_count_value_reg) &&
		modulator_level_bit == $past(rx_sync_reg))
		else $error("capture did not store count and level");
	AST_OVERFLOW: assert property (
		rx_run && count_tick && !rx_edge && !wr_count &&
		timer_count_value_reg == 16'hffff |=>
		status_reg[irc_pkg::B_OVERFLOW] ##1 irq == infrared_interrupt_enable
		|| $past(wr_control) || $past(wr_status))
		else $error("overflow not flagged");
	AST_STOPPED: assert property (
		!infrared_timer_enable && !wr_count |=> $stable(timer_count_value_reg))
		else $error("count moved while disabled");
	AST_MANUAL_PIN: assert property (
		!infrared_timer_enable |=> infrared_transmit_pin ==
		$past(manual_tx_level) && infrared_transmit_pin_oe ==
		$past(manual_tx_drive_enable))
		else $error("manual pin control not followed");
	AST_IDLE_LEVEL: assert property (
		tx_run && !level_latch_reg |=> infrared_transmit_pin ==
		$past(pol_latch_reg))
		else $error("idle level wrong while level bit clear");
	AST_FLAG_HOLD: assert property (
		status_reg[irc_pkg::B_OVERFLOW] && !wr_status |=>
		status_reg[irc_pkg::B_OVERFLOW])
		else $error("overflow flag dropped without clear");
endmodule : irc_timer
`default_nettype wire

// file: tb/irc_far_end.sv
// far end model: infrared receiver source and emitter load
`timescale 1ns/100ps
`default_nettype none
module irc_far_end (
	input wire logic aclk,
	input wire logic clr,
	input wire logic tx_pin,
	input wire logic tx_oe,
	input wire logic rx_cmd,
	output logic rx_pin,
	output logic [15:0] tx_rises
);
	logic tx_last;
	// receiver drives the commanded level
	assign rx_pin = rx_cmd;
	// emitter load counts driven rising edges
	always_ff @(posedge aclk) begin
		tx_last <= tx_pin;
		if (clr)
			tx_rises <= 16'h0000;
		else if (tx_oe && tx_pin && !tx_last)
			tx_rises <= tx_rises + 16'h0001;
	end
endmodule : irc_far_end
`default_nettype wire

// file: tb/irc_timer_bench.sv
// self-checking bench for the infrared carrier timer
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, g, e) begin comparisons++; if ((g) !== (e)) begin \
	errors++; $display("[FAIL] %s exp %h got %h", n, e, g); end end
module irc_timer_bench;
	localparam logic [7:0] CT = irc_pkg::OFF_CONTROL;
	localparam logic [7:0] CR = irc_pkg::OFF_CARRIER;
	localparam logic [7:0] MT = irc_pkg::OFF_MODTIME;
	localparam logic [7:0] CV = irc_pkg::OFF_COUNT;
	localparam logic [7:0] ST = irc_pkg::OFF_STATUS;
	logic aclk, aresetn, clr, rx_cmd, infrared_receive_pin, irq;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, d, e;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, r, pin;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic s_axi_rvalid, s_axi_rready;
	logic infrared_transmit_pin, infrared_transmit_pin_oe;
	logic [15:0] rises;
	logic [15:0] mv [3] = '{16'h1800, 16'h1000, 16'h0800};
	logic [1:0] pe [3] = '{2'b11, 2'b01, 2'b10};
	int errors, comparisons, len;
	assign pin = {infrared_transmit_pin, infrared_transmit_pin_oe};
	irc_timer i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .infrared_receive_pin,
		.infrared_transmit_pin, .infrared_transmit_pin_oe, .irq);
	irc_far_end i_far (.aclk, .clr, .tx_pin(infrared_transmit_pin),
		.tx_oe(infrared_transmit_pin_oe), .rx_cmd,
		.rx_pin(infrared_receive_pin), .tx_rises(rises));
	initial begin
		aclk = 1'b0;
		forever #4 aclk = ~aclk;
	end
	// ------------------------------------------------------------
	// bus, pin run and verdict tasks
	// ------------------------------------------------------------
	task automatic give_verdict;
		$display("errors %0d comparisons %0d", errors, comparisons);
		if (errors == 0 && comparisons > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : give_verdict
	task automatic wr(input logic [7:0] a, input logic [15:0] v,
		input logic [3:0] s);
		logic ta, tw, done;
		int n;
		done = 1'b0;
		n = 0;
		s_axi_awaddr <= a;
		s_axi_wdata <= {16'h0000, v};
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!done && n < 100) begin
			@(negedge aclk);
			ta = s_axi_awready;
			tw = s_axi_wready;
			done = s_axi_bvalid === 1'b1;
			r = s_axi_bresp;
			n++;
			@(posedge aclk);
			if (ta) s_axi_awvalid <= 1'b0;
			if (tw) s_axi_wvalid <= 1'b0;
		end
		if (!done) begin
			errors++;
			$display("[FAIL] write answer exp 1 got 0");
		end
	endtask : wr
	task automatic rd(input logic [7:0] a);
		logic ta, done;
		int n;
		done = 1'b0;
		n = 0;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		while (!done && n < 100) begin
			@(negedge aclk);
			ta = s_axi_arready;
			done = s_axi_rvalid === 1'b1;
			d = s_axi_rdata;
			r = s_axi_rresp;
			n++;
			@(posedge aclk);
			if (ta) s_axi_arvalid <= 1'b0;
		end
		if (!done) begin
			errors++;
			$display("[FAIL] read answer exp 1 got 0");
		end
	endtask : rd
	task automatic rc(input string nm, input logic [7:0] a,
		input logic [31:0] x);
		rd(a);
		`CHK(nm, d, x);
	endtask : rc
	task automatic run_len(input logic lv, output int k);
		int n;
		n = 0;
		k = 0;
		@(negedge aclk);
		while (pin[1] === lv && n < 50) begin
			@(negedge aclk);
			n++;
		end
		while (pin[1] !== lv && n < 50) begin
			@(negedge aclk);
			n++;
		end
		while (pin[1] === lv && k < 50) begin
			@(negedge aclk);
			k++;
		end
		@(posedge aclk);
	endtask : run_len
	initial begin
		repeat (20000) @(posedge aclk);
		errors++;
		$display("[FAIL] watchdog exp done got timeout");
		give_verdict();
	end
	// ------------------------------------------------------------
	// tests
	// ------------------------------------------------------------
	initial begin
		errors = 0;
		comparisons = 0;
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= '0;
		{s_axi_arvalid, s_axi_rready, rx_cmd, s_axi_wstrb} <= '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= '0;
		clr <= 1'b1;
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		clr <= 1'b0;
		@(posedge aclk);
		rc("control", CT, 32'h0);
		rc("count", CV, 32'h0);
		rc("status", ST, 32'h0);
		rc("unmapped", 8'h14, 32'h0);
		`CHK("rresp", r, irc_pkg::RESP_SLVERR);
		wr(CT, 16'hfffe, 4'h3);
		rc("control mask", CT, 32'h1ffe);
		foreach (mv[i]) begin
			wr(CT, mv[i], 4'h3);
			repeat (2) @(posedge aclk);
			`CHK("manual pin", pin, pe[i]);
		end
		wr(CR, 16'h1234, 4'h3);
		wr(CR, 16'h00ab, 4'h1);
		rc("carrier", CR, 32'h12ab);
		wr(CR, 16'h0100, 4'h3);
		wr(MT, 16'h00ff, 4'h3);
		wr(CT, 16'h0203, 4'h3);
		run_len(1'b1, len);
		`CHK("high run", len, 2);
		run_len(1'b0, len);
		`CHK("low run", len, 1);
		rd(CV);
		e = d;
		`CHK("down from time", d <= 32'hff, 1'b1);
		repeat (30) @(posedge aclk);
		rd(CV);
		`CHK("carrier ticks", (e - d) inside {[9:13]}, 1'b1);
		wr(CT, 16'h0243, 4'h3);
		run_len(1'b1, len);
		`CHK("divided high", len, 4);
		run_len(1'b0, len);
		`CHK("divided low", len, 2);
		wr(CT, 16'h0207, 4'h3);
		rd(CV);
		e = d;
		repeat (30) @(posedge aclk);
		rd(CV);
		`CHK("clock ticks", (e - d) inside {[30:40]}, 1'b1);
		repeat (300) @(posedge aclk);
		rc("event", ST, 32'h1);
		`CHK("carrier out", rises != 16'h0, 1'b1);
		wr(CT, 16'h0000, 4'h3);
		rd(CV);
		e = d;
		repeat (20) @(posedge aclk);
		rc("frozen", CV, e);
		wr(CT, 16'h0107, 4'h3);
		repeat (4) @(posedge aclk);
		clr <= 1'b1;
		@(posedge aclk);
		clr <= 1'b0;
		repeat (300) @(posedge aclk);
		`CHK("idle level", pin, 2'b11);
		`CHK("no carrier", rises, 16'h0);
		wr(CT, 16'h0000, 4'h3);
		wr(ST, 16'h0003, 4'h1);
		wr(CV, 16'hfff0, 4'h3);
		wr(CT, 16'h0405, 4'h3);
		repeat (30) @(posedge aclk);
		rc("overflow", ST, 32'h2);
		`CHK("irq", irq, 1'b1);
		rd(CV);
		`CHK("count up", d inside {[1:32'h40]}, 1'b1);
		wr(ST, 16'h0002, 4'h1);
		rc("ovf clear", ST, 32'h0);
		`CHK("irq clear", irq, 1'b0);
		wr(CT, 16'h041d, 4'h3);
		rx_cmd <= 1'b1;
		repeat (10) @(posedge aclk);
		rd(CV);
		`CHK("reload", d < 32'h20, 1'b1);
		rc("level bit", CT, 32'h061d);
		rd(MT);
		`CHK("captured time", d > 32'h0, 1'b1);
		rc("capture event", ST, 32'h1);
		wr(CT, 16'h0415, 4'h3);
		rx_cmd <= 1'b0;
		repeat (10) @(posedge aclk);
		rd(CV);
		e = d;
		rx_cmd <= 1'b1;
		repeat (10) @(posedge aclk);
		rd(CV);
		`CHK("free run", d > e, 1'b1);
		wr(CT, 16'h042d, 4'h3);
		rx_cmd <= 1'b0;
		repeat (10) @(posedge aclk);
		rd(CV);
		`CHK("both edges", d < 32'h20, 1'b1);
		give_verdict();
	end
endmodule : irc_timer_bench
`default_nettype wire
